// ==== src/lcdh_device.sv ====
// Device end of the LCD driver microprocessor port: parallel
// 8080/6800 bus or write-only serial link, plus master/slave timing.
// Assumes every link pin is asynchronous to clk and slower than it.
//
// Notes on behaviour
// - Style pin low 8080, high 6800
// - Read pin: 8080 active-low, 6800 enable high
// - Write pin: 8080 active-low, 6800 high reads
// - Parallel select high: byte bus, both strobes
// - Parallel select low: serial write-only, shift clock
// - Master select runs oscillator amplifier output
// - Master drives phase and sync, slave receives
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module lcdh_device
  import lcdh_pkg::*;
#(
  parameter int FRAME_DIV = FRAME_DIV_DEF
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pins
  lcdh_if.dev link,
  // Received bytes
  output logic wr_pulse,
  output logic wr_is_data,
  output logic [7:0] wr_byte,
  // Read requests and their answers
  output logic rd_pulse,
  output logic rd_is_data,
  input wire logic [7:0] rd_status,
  input wire logic [7:0] rd_data,
  // Timing state
  output logic phase_now,
  output logic sync_now,
  output logic is_master
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [DEV_SYNC_W-1:0] raw;
  logic [DEV_SYNC_W-1:0] s;
  logic init_s, style_s, par_s, ms_s, cs1_s, cs2_s, dc_s;
  logic rd_s, wr_s, si_s, scl_s, fb_s, ph_in_s, sy_in_s;
  logic [7:0] bus_s;

  assign raw = {link.system_init_n, link.bus_style_select,
                link.iface_parallel, link.master_slave_select,
                link.chip_sel_low, link.chip_sel_high,
                link.data_command_select, link.rd_enable,
                link.wr_direction, link.serial_data, link.serial_clk,
                link.oscillator_feedback_in, link.ac_drive_phase,
                link.bus_data_lines};
  assign {init_s, style_s, par_s, ms_s, cs1_s, cs2_s, dc_s, rd_s,
          wr_s, si_s, scl_s, fb_s, ph_in_s, bus_s} = s;

  lcdh_sync #(.W(DEV_SYNC_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(raw),
    .q(s)
  );

  // Display sync goes through a second bundle to keep widths simple
  lcdh_sync #(.W(1)) u_sync_ds (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(link.display_sync),
    .q(sy_in_s)
  );

  generate
    if (FRAME_DIV < 2 || FRAME_DIV > 65535) begin : g_chk
      $error("FRAME_DIV must lie in 2..65535");
    end
  endgenerate

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic run_rst;
  logic sel;
  logic rd_act, wr_act;
  logic pr, pw;

  assign run_rst = !rst_n || !init_s;
  assign sel = !cs1_s && cs2_s;
  // The same two pins mean different things per style
  assign rd_act = style_s ? (rd_s && wr_s) : !rd_s;
  assign wr_act = style_s ? (rd_s && !wr_s) : !wr_s;
  assign pr = sel && par_s && rd_act;
  assign pw = sel && par_s && wr_act;

  // ----------------------------------------
  // Parallel writes
  // ----------------------------------------
  logic pw_q;
  logic [7:0] lat_byte;
  logic lat_dc;
  logic par_fire;

  // Commit at strobe end so the last sampled byte is the settled one
  assign par_fire = pw_q && !pw;

  always_ff @(posedge clk) begin
    if (run_rst) begin
      pw_q <= 1'b0;
      lat_byte <= 8'h00;
      lat_dc <= 1'b0;
    end else if (ce) begin
      pw_q <= pw;
      if (pw) begin
        lat_byte <= bus_s;
        lat_dc <= dc_s;
      end
    end
  end

  // ----------------------------------------
  // Serial writes
  // ----------------------------------------
  logic scl_q;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic ser_fire;

  assign ser_fire = sel && !par_s && scl_s && !scl_q &&
                    (bit_cnt == LAST_BIT);

  always_ff @(posedge clk) begin
    if (run_rst) begin
      scl_q <= 1'b0;
      bit_cnt <= 3'h0;
      shift <= 7'h00;
    end else if (ce) begin
      scl_q <= scl_s;
      // Deselect drops a partial byte
      if (!sel || par_s) begin
        bit_cnt <= 3'h0;
      end else if (scl_s && !scl_q) begin
        shift <= {shift[5:0], si_s};
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (run_rst) begin
      wr_pulse <= 1'b0;
      wr_is_data <= 1'b0;
      wr_byte <= 8'h00;
    end else if (ce) begin
      wr_pulse <= par_fire || ser_fire;
      if (ser_fire) begin
        wr_byte <= {shift, si_s};
        wr_is_data <= dc_s;
      end else if (par_fire) begin
        wr_byte <= lat_byte;
        wr_is_data <= lat_dc;
      end
    end
  end

  // ----------------------------------------
  // Parallel reads
  // ----------------------------------------
  logic pr_q;

  always_ff @(posedge clk) begin
    if (run_rst) begin
      pr_q <= 1'b0;
      rd_pulse <= 1'b0;
      rd_is_data <= 1'b0;
      link.dev_d_out <= 8'h00;
      link.dev_d_oe <= 1'b0;
    end else if (ce) begin
      pr_q <= pr;
      rd_pulse <= pr && !pr_q;
      link.dev_d_oe <= pr;
      if (pr && !pr_q) begin
        rd_is_data <= dc_s;
        link.dev_d_out <= dc_s ? rd_data : rd_status;
      end
    end
  end

  // ----------------------------------------
  // Oscillator and frame timing
  // ----------------------------------------
  logic fb_q;
  logic [15:0] div_cnt;
  logic phase_ff;

  always_ff @(posedge clk) begin
    if (run_rst) begin
      link.oscillator_amp_out <= 1'b0;
      link.osc_amp_oe <= 1'b0;
    end else if (ce) begin
      // Inverting amplifier closes the loop through the resistor
      link.oscillator_amp_out <= ms_s && !fb_s;
      link.osc_amp_oe <= ms_s;
    end
  end

  // Frame timing counts oscillator edges, so it stops with the loop
  always_ff @(posedge clk) begin
    if (run_rst) begin
      fb_q <= 1'b0;
      div_cnt <= 16'h0000;
      phase_ff <= 1'b0;
      link.sync_out <= 1'b0;
    end else if (ce) begin
      fb_q <= fb_s;
      if (ms_s && fb_s && !fb_q) begin
        if (div_cnt == 16'(FRAME_DIV - 1)) begin
          div_cnt <= 16'h0000;
          phase_ff <= !phase_ff;
          link.sync_out <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 16'h0001;
          link.sync_out <= 1'b0;
        end
      end
    end
  end

  assign link.phase_out = phase_ff;

  always_ff @(posedge clk) begin
    if (run_rst) begin
      link.phase_oe <= 1'b0;
      link.sync_oe <= 1'b0;
      is_master <= 1'b0;
      phase_now <= 1'b0;
      sync_now <= 1'b0;
    end else if (ce) begin
      link.phase_oe <= ms_s;
      link.sync_oe <= ms_s;
      is_master <= ms_s;
      phase_now <= ms_s ? phase_ff : ph_in_s;
      sync_now <= ms_s ? link.sync_out : sy_in_s;
    end
  end
endmodule

// ==== src/lcdh_pkg.sv ====
// Shared constants for both ends of the LCD driver host port.
// Assumes a 100 MHz system clock on both ends.
package lcdh_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int SETUP_NS = 40;
  localparam int STROBE_NS = 80;
  localparam int SCL_HALF_NS = 60;

  // Least times round up to whole cycles, never below one
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC = ceil_cyc(SETUP_NS);
  localparam int STROBE_CYC = ceil_cyc(STROBE_NS);
  localparam int SCL_HALF_CYC = ceil_cyc(SCL_HALF_NS);

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int BUS_W = 8;
  localparam int DEV_SYNC_W = 21;
  localparam int FRAME_DIV_DEF = 16;
  localparam logic [7:0] BUS_IDLE = 8'hFF;
  localparam logic [7:0] SER_READ_FILL = 8'hFF;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------
  // Host sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_SETUP = 5'h02,
    H_STROBE = 5'h04,
    H_HOLD = 5'h08,
    H_SERIAL = 5'h10
  } lcdh_hstate_t;

endpackage

// ==== src/lcdh_if.sv ====
// Pin-level link between the host and the LCD driver host port.
// Assumes the bench drives the oscillator feedback and, for a slave
// device, the external phase and sync levels.
`timescale 1ns/1ps
interface lcdh_if;
  import lcdh_pkg::*;

  // Host driven pins
  logic system_init_n;
  logic bus_style_select;
  logic iface_parallel;
  logic master_slave_select;
  logic chip_sel_low;
  logic chip_sel_high;
  logic data_command_select;
  logic rd_enable;
  logic wr_direction;
  logic serial_data;
  logic serial_clk;
  logic [7:0] host_d_out;
  logic host_d_oe;
  // Device driven pins
  logic [7:0] dev_d_out;
  logic dev_d_oe;
  logic phase_out;
  logic phase_oe;
  logic sync_out;
  logic sync_oe;
  logic oscillator_amp_out;
  logic osc_amp_oe;
  // Bench driven levels
  logic oscillator_feedback_in;
  logic ext_phase;
  logic ext_sync;
  // Resolved wires; an undriven bus floats high
  logic [7:0] bus_data_lines;
  logic ac_drive_phase;
  logic display_sync;

  assign bus_data_lines = dev_d_oe ? dev_d_out :
                          host_d_oe ? host_d_out : BUS_IDLE;
  assign ac_drive_phase = phase_oe ? phase_out : ext_phase;
  assign display_sync = sync_oe ? sync_out : ext_sync;

  modport dev (
    input system_init_n, bus_style_select, iface_parallel,
    input master_slave_select, chip_sel_low, chip_sel_high,
    input data_command_select, rd_enable, wr_direction,
    input serial_data, serial_clk, bus_data_lines,
    input oscillator_feedback_in, ac_drive_phase, display_sync,
    output dev_d_out, dev_d_oe, phase_out, phase_oe,
    output sync_out, sync_oe, oscillator_amp_out, osc_amp_oe
  );

  modport host (
    output system_init_n, bus_style_select, iface_parallel,
    output master_slave_select, chip_sel_low, chip_sel_high,
    output data_command_select, rd_enable, wr_direction,
    output serial_data, serial_clk, host_d_out, host_d_oe,
    input bus_data_lines
  );
endinterface

// ==== src/lcdh_sync.sv ====
// Two-stage synchroniser for a bundle of pin levels.
// Assumes each bit is a level that is stable for several clocks.
`timescale 1ns/1ps
module lcdh_sync #(
  parameter int W = 1
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q <= '0;
    end else if (ce) begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

// ==== src/lcdh_host.sv ====
// Host end of the LCD driver port: runs parallel 8080/6800 cycles or
// serial writes from single requests, and drives the mode pins.
// Assumes the device end samples every pin through two flip-flops.
`timescale 1ns/1ps
module lcdh_host
  import lcdh_pkg::*;
#(
  parameter int SCL_HALF = SCL_HALF_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pins
  lcdh_if.host link,
  // Configuration levels
  input wire logic cfg_init_n,
  input wire logic cfg_parallel,
  input wire logic cfg_6800,
  input wire logic cfg_master,
  // Requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_dc,
  input wire logic [7:0] req_byte,
  output logic req_ready,
  // Answers
  output logic rsp_valid,
  output logic [7:0] rsp_byte
);

  generate
    if (SCL_HALF < 4 || SCL_HALF > 255) begin : g_chk
      $error("SCL_HALF must lie in 4..255");
    end
  endgenerate

  logic [7:0] bus_s;

  lcdh_sync #(.W(BUS_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(link.bus_data_lines),
    .q(bus_s)
  );

  // ----------------------------------------
  // Mode pins
  // ----------------------------------------
  // Mode changes only between cycles, or the device would misdecode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.system_init_n <= 1'b0;
      link.iface_parallel <= 1'b1;
      link.bus_style_select <= 1'b0;
      link.master_slave_select <= 1'b0;
    end else if (ce && req_ready) begin
      link.system_init_n <= cfg_init_n;
      link.iface_parallel <= cfg_parallel;
      link.bus_style_select <= cfg_6800;
      link.master_slave_select <= cfg_master;
    end
  end

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  lcdh_hstate_t st_ff;
  logic [7:0] cnt_ff;
  logic [2:0] bit_ff;
  logic wr_ff;
  logic [7:0] byte_ff;
  logic s68;

  assign s68 = link.bus_style_select;
  assign req_ready = (st_ff == H_IDLE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= H_IDLE;
      cnt_ff <= 8'h00;
      bit_ff <= 3'h0;
      wr_ff <= 1'b0;
      byte_ff <= 8'h00;
      link.chip_sel_low <= 1'b1;
      link.chip_sel_high <= 1'b0;
      link.data_command_select <= 1'b0;
      link.rd_enable <= 1'b1;
      link.wr_direction <= 1'b1;
      link.serial_data <= 1'b0;
      link.serial_clk <= 1'b0;
      link.host_d_out <= 8'h00;
      link.host_d_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_byte <= 8'h00;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      case (st_ff)
        H_IDLE: begin
          // Idle strobe levels: 8080 both high, 6800 E low, R/W high
          link.rd_enable <= !s68 || !link.iface_parallel;
          link.wr_direction <= 1'b1;
          link.serial_clk <= 1'b0;
          if (req_valid) begin
            wr_ff <= req_write;
            byte_ff <= req_byte;
            if (link.iface_parallel) begin
              link.chip_sel_low <= 1'b0;
              link.chip_sel_high <= 1'b1;
              link.data_command_select <= req_dc;
              link.host_d_out <= req_byte;
              link.host_d_oe <= req_write;
              if (s68) begin
                link.wr_direction <= !req_write;
              end
              cnt_ff <= 8'(SETUP_CYC - 1);
              st_ff <= H_SETUP;
            end else if (req_write) begin
              link.chip_sel_low <= 1'b0;
              link.chip_sel_high <= 1'b1;
              link.data_command_select <= req_dc;
              link.serial_data <= req_byte[7];
              bit_ff <= LAST_BIT;
              cnt_ff <= 8'(SCL_HALF - 1);
              st_ff <= H_SERIAL;
            end else begin
              // The serial link cannot read; answer with a fill byte
              rsp_valid <= 1'b1;
              rsp_byte <= SER_READ_FILL;
            end
          end
        end
        H_SETUP: begin
          if (cnt_ff == 8'h00) begin
            if (s68) begin
              link.rd_enable <= 1'b1;
            end else if (wr_ff) begin
              link.wr_direction <= 1'b0;
            end else begin
              link.rd_enable <= 1'b0;
            end
            cnt_ff <= 8'(STROBE_CYC - 1);
            st_ff <= H_STROBE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        H_STROBE: begin
          if (cnt_ff == 8'h00) begin
            if (!wr_ff) begin
              rsp_byte <= bus_s;
            end
            link.rd_enable <= !s68;
            if (!s68) begin
              link.wr_direction <= 1'b1;
            end
            cnt_ff <= 8'(SETUP_CYC - 1);
            st_ff <= H_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        H_SERIAL: begin
          if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else if (!link.serial_clk) begin
            link.serial_clk <= 1'b1;
            cnt_ff <= 8'(SCL_HALF - 1);
          end else begin
            link.serial_clk <= 1'b0;
            cnt_ff <= 8'(SCL_HALF - 1);
            if (bit_ff == 3'h0) begin
              st_ff <= H_HOLD;
            end else begin
              bit_ff <= bit_ff - 3'h1;
              link.serial_data <= byte_ff[bit_ff - 3'h1];
            end
          end
        end
        H_HOLD: begin
          if (cnt_ff == 8'h00) begin
            link.chip_sel_low <= 1'b1;
            link.chip_sel_high <= 1'b0;
            link.host_d_oe <= 1'b0;
            link.wr_direction <= 1'b1;
            rsp_valid <= !wr_ff;
            st_ff <= H_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: begin
          st_ff <= H_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== sim/lcdh_chk.sv ====
// Concurrent checks on the pins between host and device ends.
// Assumes ce is held high on both ends for the whole run.
`timescale 1ns/1ps
module lcdh_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host driven pins
  input wire logic system_init_n,
  input wire logic bus_style_select,
  input wire logic iface_parallel,
  input wire logic master_slave_select,
  input wire logic chip_sel_low,
  input wire logic chip_sel_high,
  input wire logic rd_enable,
  input wire logic wr_direction,
  input wire logic host_d_oe,
  // Device driven pins
  input wire logic dev_d_oe,
  input wire logic phase_oe,
  input wire logic sync_oe,
  input wire logic oscillator_amp_out,
  input wire logic osc_amp_oe,
  // Bench driven level
  input wire logic oscillator_feedback_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_sel;
    !chip_sel_low && chip_sel_high && iface_parallel;
  endsequence
  sequence s_rd80;
    s_sel ##0 (!bus_style_select && $fell(rd_enable));
  endsequence
  sequence s_rd68;
    s_sel ##0 (bus_style_select && wr_direction && $rose(rd_enable));
  endsequence
  sequence s_master;
    (master_slave_select && system_init_n)[*6];
  endsequence

  chk_read_drives: assert property (s_rd80 |-> ##[1:4] dev_d_oe)
    else $error("low read strobe did not drive the bus");
  chk_e_read_drives: assert property (s_rd68 |-> ##[1:4] dev_d_oe)
    else $error("enable with read direction did not drive the bus");
  chk_one_strobe: assert property (
    s_sel ##0 (!bus_style_select && !wr_direction) |-> rd_enable)
    else $error("both low strobes active together");
  chk_no_contention: assert property (host_d_oe |-> !dev_d_oe)
    else $error("host and device drive the bus together");
  chk_desel_quiet: assert property (
    (chip_sel_low || !chip_sel_high)[*4] |-> !dev_d_oe)
    else $error("deselected device drives the bus");
  chk_serial_quiet: assert property ((!iface_parallel)[*4] |-> !dev_d_oe)
    else $error("device drives the bus in serial mode");
  chk_init_quiet: assert property (
    (!system_init_n)[*4] |-> !dev_d_oe && !phase_oe)
    else $error("device drives pins while held in init");
  chk_master_drives: assert property (
    s_master |-> phase_oe && sync_oe && osc_amp_oe)
    else $error("master does not drive phase, sync or amplifier");
  chk_slave_listens: assert property ((!master_slave_select)[*4] |->
    !phase_oe && !sync_oe && !osc_amp_oe)
    else $error("slave drives phase, sync or amplifier");
  chk_amp_inverts: assert property ((osc_amp_oe && system_init_n &&
    $stable(oscillator_feedback_in))[*5] |->
    oscillator_amp_out == !oscillator_feedback_in)
    else $error("amplifier output is not the inverted feedback");
endmodule

// ==== sim/test_lcd_driver_host_interface.sv ====
// Testbench joining host and device ends, plus a bench-driven fault end.
// Assumes the design sources and lcdh_chk are compiled before it.
`timescale 1ns/1ps
module test_lcd_driver_host_interface;
  import lcdh_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int err_count = 0;
  int checked = 0;
  logic cfg_init_n, cfg_parallel, cfg_6800, cfg_master;
  logic req_valid, req_write, req_dc, req_ready, rsp_valid;
  logic [7:0] req_byte, rsp_byte, rd_status, rd_data, wr_byte;
  logic wr_pulse, wr_is_data, rd_pulse, rd_is_data, phase_now, is_master;
  logic f_wr_pulse, got_dc, got_rd_dc, sync_now;
  logic [7:0] got_byte, got_rsp, bus_seen, ser_seen;
  int n_wr = 0, n_rd = 0, n_rsp = 0, n_fwr = 0;

  always #5 clk = ~clk;

  lcdh_if link ();
  lcdh_if flt ();
  // Feedback oscillator, offset so that its edges never meet a clk edge
  initial begin
    #2;
    forever #62.5 link.oscillator_feedback_in = ~link.oscillator_feedback_in;
  end
  lcdh_host lcdh_host_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .link(link.host), .cfg_init_n(cfg_init_n), .cfg_parallel(cfg_parallel),
    .cfg_6800(cfg_6800), .cfg_master(cfg_master), .req_valid(req_valid),
    .req_write(req_write), .req_dc(req_dc), .req_byte(req_byte),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
  lcdh_device lcdh_device_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .link(link.dev), .wr_pulse(wr_pulse), .wr_is_data(wr_is_data),
    .wr_byte(wr_byte), .rd_pulse(rd_pulse), .rd_is_data(rd_is_data),
    .rd_status(rd_status), .rd_data(rd_data), .phase_now(phase_now),
    .sync_now(sync_now), .is_master(is_master));
  // Second device, its pins driven by the bench to break the rules
  lcdh_device lcdh_device_fault_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .link(flt.dev), .wr_pulse(f_wr_pulse), .wr_is_data(), .wr_byte(),
    .rd_pulse(), .rd_is_data(), .rd_status(rd_status), .rd_data(rd_data),
    .phase_now(), .sync_now(), .is_master());
  lcdh_chk lcdh_chk_inst (.clk(clk), .rst_n(rst_n),
    .system_init_n(link.system_init_n),
    .bus_style_select(link.bus_style_select),
    .iface_parallel(link.iface_parallel),
    .master_slave_select(link.master_slave_select),
    .chip_sel_low(link.chip_sel_low), .chip_sel_high(link.chip_sel_high),
    .rd_enable(link.rd_enable), .wr_direction(link.wr_direction),
    .host_d_oe(link.host_d_oe), .dev_d_oe(link.dev_d_oe),
    .phase_oe(link.phase_oe), .sync_oe(link.sync_oe),
    .oscillator_amp_out(link.oscillator_amp_out),
    .osc_amp_oe(link.osc_amp_oe),
    .oscillator_feedback_in(link.oscillator_feedback_in));

  // --------------------------------
  // Monitors
  // --------------------------------
  always @(posedge clk) begin
    if (wr_pulse === 1'b1) begin
      n_wr <= n_wr + 1;
      got_byte <= wr_byte;
      got_dc <= wr_is_data;
    end
    if (rd_pulse === 1'b1) begin
      n_rd <= n_rd + 1;
      got_rd_dc <= rd_is_data;
    end
    if (rsp_valid === 1'b1) begin
      n_rsp <= n_rsp + 1;
      got_rsp <= rsp_byte;
    end
    if (f_wr_pulse === 1'b1) begin
      n_fwr <= n_fwr + 1;
    end
  end
  // Byte on the wire at the end of a write strobe, either style
  always @(posedge link.wr_direction) begin
    if (rst_n && !link.bus_style_select && link.iface_parallel) begin
      bus_seen <= link.bus_data_lines;
      check("cs pins", {6'h0, link.chip_sel_low, link.chip_sel_high},
        8'h01);
    end
  end
  always @(negedge link.rd_enable) begin
    if (link.bus_style_select && !link.wr_direction) begin
      bus_seen <= link.bus_data_lines;
    end
  end
  always @(posedge link.serial_clk) begin
    ser_seen <= {ser_seen[6:0], link.serial_data};
  end

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic check(input string nm, input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk);
    while (req_ready !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) err_count++;
    repeat (6) @(posedge clk);
  endtask
  task automatic req(input logic w, dc, input logic [7:0] b);
    req_valid <= 1'b1;
    req_write <= w;
    req_dc <= dc;
    req_byte <= b;
    @(posedge clk);
    req_valid <= 1'b0;
    wait_idle();
  endtask
  task automatic wr_test(input logic dc, input logic [7:0] b, input int n);
    int w0;
    w0 = n_wr;
    req(1'b1, dc, b);
    check("wr count", 8'(n_wr - w0), 8'(n));
    if (n == 1) check("wr byte", got_byte, b);
    if (n == 1) check("wr dc", {7'h0, got_dc}, {7'h0, dc});
  endtask
  task automatic rd_test(input logic dc, input logic [7:0] exp);
    int r0;
    r0 = n_rsp;
    req(1'b0, dc, 8'h00);
    check("rsp count", 8'(n_rsp - r0), 8'h01);
    check("rsp byte", got_rsp, exp);
  endtask
  task automatic flt_wr(input logic csl, csh);
    flt.chip_sel_low <= csl;
    flt.chip_sel_high <= csh;
    repeat (4) @(posedge clk);
    flt.wr_direction <= 1'b0;
    repeat (8) @(posedge clk);
    flt.wr_direction <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    int r0;
    {cfg_init_n, cfg_parallel, cfg_6800, cfg_master} = 4'hD;
    {req_valid, req_write, req_dc} = 3'h0;
    req_byte = 8'h00;
    rd_status = 8'h3C;
    rd_data = 8'hC3;
    {link.oscillator_feedback_in, link.ext_phase, link.ext_sync} = 3'h0;
    {flt.system_init_n, flt.bus_style_select, flt.iface_parallel} = 3'h5;
    {flt.master_slave_select, flt.chip_sel_low, flt.chip_sel_high} = 3'h2;
    {flt.data_command_select, flt.rd_enable, flt.wr_direction} = 3'h7;
    {flt.serial_data, flt.serial_clk, flt.host_d_oe} = 3'h1;
    flt.host_d_out = 8'h11;
    {flt.oscillator_feedback_in, flt.ext_phase, flt.ext_sync} = 3'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_idle();
    for (int s = 0; s < 2; s++) begin
      cfg_6800 <= s[0];
      // Stale byte from the other style must not satisfy the wire check
      bus_seen <= 8'h00;
      wait_idle();
      wr_test(1'b0, 8'h5A, 1);
      wr_test(1'b1, 8'hA5, 1);
      check("bus wire", bus_seen, 8'hA5);
      rd_test(1'b0, 8'h3C);
      check("rd dc", {7'h0, got_rd_dc}, 8'h00);
      rd_test(1'b1, 8'hC3);
      check("rd dc", {7'h0, got_rd_dc}, 8'h01);
    end
    check("master", {7'h0, is_master}, 8'h01);
    cfg_parallel <= 1'b0;
    wait_idle();
    wr_test(1'b1, 8'h96, 1);
    check("serial wire", ser_seen, 8'h96);
    r0 = n_rd;
    rd_test(1'b0, SER_READ_FILL);
    check("serial no read", 8'(n_rd - r0), 8'h00);
    cfg_parallel <= 1'b1;
    cfg_init_n <= 1'b0;
    wait_idle();
    wr_test(1'b1, 8'h33, 0);
    cfg_init_n <= 1'b1;
    cfg_master <= 1'b0;
    link.ext_phase <= 1'b1;
    link.ext_sync <= 1'b1;
    wait_idle();
    check("init clears byte", wr_byte, 8'h00);
    wr_test(1'b0, 8'hC6, 1);
    check("slave", {7'h0, is_master}, 8'h00);
    check("slave phase", {7'h0, phase_now}, 8'h01);
    check("slave sync", {7'h0, sync_now}, 8'h01);
    link.ext_phase <= 1'b0;
    link.ext_sync <= 1'b0;
    wait_idle();
    check("slave phase", {7'h0, phase_now}, 8'h00);
    check("slave sync", {7'h0, sync_now}, 8'h00);
    r0 = n_fwr;
    flt_wr(1'b1, 1'b1);
    flt_wr(1'b0, 1'b0);
    flt_wr(1'b1, 1'b0);
    check("deselected writes", 8'(n_fwr - r0), 8'h00);
    // Selected, so only the parallel mode keeps these edges out
    flt.chip_sel_low <= 1'b0;
    flt.chip_sel_high <= 1'b1;
    repeat (8) begin
      flt.serial_clk <= 1'b1;
      repeat (4) @(posedge clk);
      flt.serial_clk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    check("clock in parallel", 8'(n_fwr - r0), 8'h00);
    flt_wr(1'b0, 1'b1);
    check("selected write", 8'(n_fwr - r0), 8'h01);
    print_verdict();
  end

  // Whole run needs about 600 cycles
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
endmodule
